// ===== verilog/disp_host_end.sv
// Host end: issues one byte per request on the strapped bus.
// Assumes device end samples pins through two flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "disp_port_defines.svh"
module disp_host_end
	import disp_port_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [1:0] mode_i, // Bus to strap
	input wire logic req_valid_i, // Request pulse or level
	input wire logic req_read_i, // Read request (parallel only)
	input wire logic req_dc_i, // Data (1) or command (0)
	input wire logic [7:0] req_data_i,
	input wire logic chip_reset_i, // Hold controller in reset
	output logic req_ready_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	disp_port_if.host port
);
	host_state_type st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt; // Phase timer
	logic [3:0] bit_r, bit_nxt; // Bits left to shift
	logic [7:0] sh_r, sh_nxt;
	logic rd_r, rd_nxt, dc_r, dc_nxt, cs_n_r, cs_n_nxt, ctl_a_r, ctl_a_nxt, ctl_b_r, ctl_b_nxt;
	logic sck_r, sck_nxt, rv_r, rv_nxt, rdy_r, rdy_nxt;
	logic [7:0] rdd_r, rdd_nxt;
	logic [1:0] mode_r;
	logic chip_rst_n_r; // Controller reset pin, registered
	logic [7:0] din_s1_r, din_s2_r; // Bus read back through two flops
	logic par;
	assign par = mode_r[1];
	////////////////////////////////////////////////////////////
	// Next state of the cycle sequencer
	always_comb
	begin
		st_nxt = st_r; cnt_nxt = cnt_r; bit_nxt = bit_r; sh_nxt = sh_r; rd_nxt = rd_r;
		dc_nxt = dc_r; cs_n_nxt = cs_n_r; ctl_a_nxt = ctl_a_r; ctl_b_nxt = ctl_b_r;
		sck_nxt = sck_r; rv_nxt = 1'b0; rdy_nxt = 1'b0; rdd_nxt = rdd_r;
		case (st_r)
			h_idle:
			begin
				// Idle strobes: 6800 E low, 8080 both high, serial grounded
				// Follows the strap being latched now, so strobes and straps change together
				ctl_a_nxt = (mode_i == `BUS_SEL_8080);
				ctl_b_nxt = (mode_i == `BUS_SEL_8080);
				if (req_valid_i && rdy_r)
				begin
					sh_nxt = req_data_i; rd_nxt = req_read_i & par; dc_nxt = req_dc_i;
					cs_n_nxt = 1'b0;
					if (mode_r == `BUS_SEL_6800)
						ctl_a_nxt = req_read_i;
					cnt_nxt = `HOST_HALF_PERIOD; bit_nxt = 4'h8; sck_nxt = 1'b0;
					st_nxt = par ? h_setup : h_shift;
				end
				else
					rdy_nxt = 1'b1;
			end
			h_setup:
			begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h0)
				begin
					if (mode_r == `BUS_SEL_6800)
						ctl_b_nxt = 1'b1;
					else if (rd_r)
						ctl_b_nxt = 1'b0;
					else
						ctl_a_nxt = 1'b0;
					cnt_nxt = `HOST_HALF_PERIOD; st_nxt = h_strobe;
				end
			end
			h_strobe:
			begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h0)
				begin
					ctl_a_nxt = (mode_r == `BUS_SEL_8080) | (ctl_a_r & (mode_r == `BUS_SEL_6800));
					ctl_b_nxt = (mode_r == `BUS_SEL_8080);
					cnt_nxt = `HOST_HALF_PERIOD; st_nxt = h_hold;
				end
			end
			h_shift:
			begin
				// MSB first, change on falling, device samples rising
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h0)
				begin
					cnt_nxt = `HOST_HALF_PERIOD;
					sck_nxt = ~sck_r;
					if (sck_r)
					begin
						sh_nxt = {sh_r[6:0], 1'b0}; bit_nxt = bit_r - 4'h1;
						if (bit_r == 4'h1)
							st_nxt = h_hold;
					end
				end
			end
			h_hold:
			begin
				cnt_nxt = cnt_r - 4'h1;
				// Read data taken here: the device answer lags the strobe by its synchroniser
				if (cnt_r == 4'h3)
				begin
					rdd_nxt = din_s2_r;
					rv_nxt = rd_r;
				end
				if (cnt_r == 4'h0)
				begin
					cs_n_nxt = 1'b1; rd_nxt = 1'b0; st_nxt = h_idle;
				end
			end
			default: st_nxt = h_idle;
		endcase
	end
	////////////////////////////////////////////////////////////
	// State registers; strap latched each cycle only while idle
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_r <= h_idle; cnt_r <= 4'h0; bit_r <= 4'h0; sh_r <= 8'h00; rd_r <= 1'b0;
			dc_r <= 1'b0; cs_n_r <= 1'b1; ctl_a_r <= 1'b0; ctl_b_r <= 1'b0; sck_r <= 1'b0;
			rv_r <= 1'b0; rdy_r <= 1'b0; rdd_r <= 8'h00; mode_r <= 2'h0;
			din_s1_r <= 8'h00; din_s2_r <= 8'h00; chip_rst_n_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt; cnt_r <= cnt_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt; rd_r <= rd_nxt;
			dc_r <= dc_nxt; cs_n_r <= cs_n_nxt; ctl_a_r <= ctl_a_nxt; ctl_b_r <= ctl_b_nxt;
			sck_r <= sck_nxt; rv_r <= rv_nxt; rdy_r <= rdy_nxt; rdd_r <= rdd_nxt;
			if (st_r == h_idle)
				mode_r <= mode_i;
			din_s1_r <= port.d_in;
			din_s2_r <= din_s1_r;
			chip_rst_n_r <= ~chip_reset_i;
		end
	end
	////////////////////////////////////////////////////////////
	// Pin drive; all from flops
	assign port.bus_sel = mode_r;
	assign port.cs_n = cs_n_r;
	assign port.reset_in_n = chip_rst_n_r;
	assign port.dc = dc_r;
	assign port.rw_wr_n = ctl_a_r;
	assign port.e_rd_n = ctl_b_r;
	// Parallel: whole byte; serial: clock on bit0, data on bit1
	assign port.d_host = par ? sh_r : {5'h00, 1'b0, sh_r[7], sck_r};
	assign port.d_host_oe = par ? {8{~rd_r & ~cs_n_r}} : 8'h03;
	assign req_ready_o = rdy_r;
	assign rd_valid_o = rv_r;
	assign rd_data_o = rdd_r;
endmodule : disp_host_end
`default_nettype wire

// ===== verilog/disp_port_defines.svh
// Constants for the display host port: strap codes, pin positions, counts.
// Assumes a single 100 MHz system clock on both ends.
`ifndef DISP_PORT_DEFINES_SVH
`define DISP_PORT_DEFINES_SVH
`define BUS_SEL_6800 2'h2
`define BUS_SEL_8080 2'h3
`define BUS_SEL_SERIAL 2'h0
`define BUS_SEL_I2C 2'h1
`define PIN_SCLK 0
`define PIN_SERIAL_DATA_IN 1
`define PIN_SDA_OUT 2
`define I2C_ADDR_BASE 7'h3C
`define HOST_HALF_PERIOD 4'h4
`define READ_DATA_RESET 8'hA5
`define BIT_COUNT_LAST 3'h7
`endif

// ===== verilog/disp_port_pkg.sv
// Types shared by both ends of the display host port.
// Assumes the defines header sits beside it.
package disp_port_pkg;
	typedef enum logic [1:0] {mode_serial_type_e = 2'b00, mode_i2c_e = 2'b01,
		mode_6800_e = 2'b10, mode_8080_e = 2'b11} bus_mode_type;
	typedef enum logic [2:0] {h_idle = 3'b000, h_setup = 3'b001, h_strobe = 3'b010,
		h_hold = 3'b011, h_shift = 3'b100} host_state_type;
endpackage : disp_port_pkg

// ===== verilog/disp_port_if.sv
// Pins between host and display controller.
// Assumes the testbench resolves the data bus from the enables.
`timescale 1ns/1ps
`default_nettype none
interface disp_port_if;
	logic [1:0] bus_sel; // Straps, high strap in bit 1
	logic cs_n; // Chip select, active low
	logic reset_in_n; // Controller reset, active low
	logic dc; // Data/command, address lsb in I2C
	logic rw_wr_n; // Direction or write strobe
	logic e_rd_n; // Enable or read strobe
	logic [7:0] d_host; // Host drive of data bus
	logic [7:0] d_host_oe; // Host drive enables
	logic [7:0] d_dev; // Device drive of data bus
	logic [7:0] d_dev_oe; // Device drive enables
	logic [7:0] d_in; // Resolved bus level
	modport host (output bus_sel, cs_n, reset_in_n, dc, rw_wr_n, e_rd_n, d_host, d_host_oe, input d_in);
	modport dev (input bus_sel, cs_n, reset_in_n, dc, rw_wr_n, e_rd_n, d_in, output d_dev, d_dev_oe);
endinterface : disp_port_if
`default_nettype wire

// ===== verilog/disp_dev_end.sv
// Device end: decodes the strapped bus and emits data/command bytes.
// Assumes host pins are asynchronous; two-entry buffer to the user.
`timescale 1ns/1ps
`default_nettype none
`include "disp_port_defines.svh"
module disp_dev_end
	import disp_port_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] read_data_i, // Byte returned on reads
	input wire logic out_ready_i, // User accepts a byte
	output logic out_valid_o,
	output logic out_is_data_o, // 1 display data, 0 command
	output logic [7:0] out_byte_o,
	output logic init_o, // Controller initializing
	disp_port_if.dev port
);
	logic [14:0] s1_r, s2_r; // Two-flop synchronisers
	logic [14:0] pins;
	logic [1:0] md;
	logic rst_n; // Controller reset pin after the synchroniser
	logic cs_n, dcs, rw, er, sclk, serial_data_in;
	logic [7:0] bus;
	logic prv_r, prv_nxt, sck_q_r;
	logic [7:0] sh_r, sh_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic push;
	logic [8:0] push_word;
	logic [8:0] buf_r [0:1];
	logic [1:0] fill_r;
	logic wr_ptr_r, rd_ptr_r;
	logic drv_r;
	assign pins = {port.bus_sel, port.reset_in_n, port.cs_n, port.dc, port.rw_wr_n, port.e_rd_n, port.d_in};
	assign {md, rst_n, cs_n, dcs, rw, er, bus} = s2_r;
	assign sclk = bus[`PIN_SCLK];
	assign serial_data_in = bus[`PIN_SERIAL_DATA_IN];
	////////////////////////////////////////////////////////////
	// Strobe edge detect and serial shifter, next values
	always_comb
	begin
		prv_nxt = prv_r; sh_nxt = sh_r; cnt_nxt = cnt_r; push = 1'b0;
		push_word = {dcs, bus};
		case (md)
			`BUS_SEL_6800:
			begin
				prv_nxt = er & ~cs_n;
				if (er & ~cs_n & ~prv_r & ~rw)
					push = 1'b1;
			end
			`BUS_SEL_8080:
			begin
				prv_nxt = ~rw & ~cs_n;
				if (~rw & ~cs_n & ~prv_r)
					push = 1'b1;
			end
			`BUS_SEL_SERIAL:
			begin
				if (cs_n)
					cnt_nxt = 3'h0;
				else if (sclk & ~sck_q_r)
				begin
					sh_nxt = {sh_r[6:0], serial_data_in};
					cnt_nxt = cnt_r + 3'h1;
					if (cnt_r == `BIT_COUNT_LAST)
						push = 1'b1;
				end
				push_word = {dcs, sh_r[6:0], serial_data_in};
			end
			default:
			begin
				// I2C: dc is address lsb, no data path here
				push_word = {1'b0, `I2C_ADDR_BASE, dcs};
			end
		endcase
		if (fill_r == 2'h2)
			push = 1'b0; // Full: the new word is dropped so held words are not overwritten
	end
	////////////////////////////////////////////////////////////
	// Registers, synchronisers and two-entry buffer
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s1_r <= 15'h0000; s2_r <= 15'h0000; prv_r <= 1'b0; sck_q_r <= 1'b0;
			sh_r <= 8'h00; cnt_r <= 3'h0; fill_r <= 2'h0; wr_ptr_r <= 1'b0; rd_ptr_r <= 1'b0;
			buf_r[0] <= 9'h000; buf_r[1] <= 9'h000; drv_r <= 1'b0; init_o <= 1'b1;
		end
		else
		begin
			s1_r <= pins; s2_r <= s1_r;
			// Reset pin is asynchronous, so only the second flop is read
			init_o <= ~rst_n;
			prv_r <= prv_nxt; sck_q_r <= sclk; sh_r <= sh_nxt; cnt_r <= cnt_nxt;
			if (push)
			begin
				buf_r[wr_ptr_r] <= push_word;
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (out_valid_o & out_ready_i)
				rd_ptr_r <= ~rd_ptr_r;
			fill_r <= fill_r + {1'b0, push} - {1'b0, out_valid_o & out_ready_i};
			drv_r <= ~cs_n & ((md == `BUS_SEL_8080 & ~er) | (md == `BUS_SEL_6800 & er & rw));
		end
	end
	assign out_valid_o = (fill_r != 2'h0);
	assign out_is_data_o = buf_r[rd_ptr_r][8];
	assign out_byte_o = buf_r[rd_ptr_r][7:0];
	assign port.d_dev = read_data_i;
	assign port.d_dev_oe = {8{drv_r}};
endmodule : disp_dev_end
`default_nettype wire

// ===== verification/disp_port_assertions.sv
// Pin checks between the host end and the device end of the display port.
// Assumes the bench top feeds it the interface signals beside the link.
`timescale 1ns/1ps
`default_nettype none
`include "disp_port_defines.svh"
module disp_port_assertions (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [1:0] bus_sel,
	input wire logic cs_n,
	input wire logic rw_wr_n,
	input wire logic e_rd_n,
	input wire logic [7:0] d_dev_oe
);
	////////////////////////////////////////////////////////////////////////
	// One clock domain; reset mutes every check
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	AST_SER_GND: assert property (bus_sel == `BUS_SEL_SERIAL |-> !rw_wr_n && !e_rd_n)
		else $error("strobe not grounded in serial mode");
	AST_SER_NODRV: assert property (bus_sel == `BUS_SEL_SERIAL |-> d_dev_oe == 8'h00)
		else $error("device drives bus in serial mode");
	AST_I2C_BIT2: assert property (bus_sel == `BUS_SEL_I2C |-> (d_dev_oe & 8'hFB) == 8'h00)
		else $error("device drives a pin other than bit 2 in two-wire mode");
	// Six quiet cycles leave room for the two-flop pin synchroniser
	AST_CS_IDLE: assert property ((cs_n && bus_sel[1])[*6] |-> d_dev_oe == 8'h00)
		else $error("device drives bus while deselected");
	AST_6800_WR: assert property ((bus_sel == `BUS_SEL_6800 && !rw_wr_n)[*6] |-> d_dev_oe == 8'h00)
		else $error("device drives bus in a write cycle");
	AST_6800_RD: assert property (
		$rose(e_rd_n) && bus_sel == `BUS_SEL_6800 && !cs_n && rw_wr_n |-> ##[1:4] d_dev_oe == 8'hFF)
		else $error("device does not answer an enable read");
	// The write strobe stands one five-cycle phase inside the select
	AST_8080_WR: assert property (
		$fell(rw_wr_n) && bus_sel == `BUS_SEL_8080 |-> !cs_n throughout ((!rw_wr_n)[*5] ##1 rw_wr_n))
		else $error("write strobe shape wrong");
	AST_8080_RD: assert property (
		$fell(e_rd_n) && bus_sel == `BUS_SEL_8080 && !cs_n |-> ##[1:4] d_dev_oe == 8'hFF)
		else $error("device does not answer a read strobe");
	AST_8080_NORD: assert property ((bus_sel == `BUS_SEL_8080 && e_rd_n)[*6] |-> d_dev_oe == 8'h00)
		else $error("device drives bus without a read strobe");
endmodule : disp_port_assertions
`default_nettype wire

// ===== verification/display_module_host_interface_tb.sv
// Bench joining host end and device end through the pin interface.
// Assumes a 100 MHz clock; resolves the shared data pins itself.
`timescale 1ns/1ps
`default_nettype none
`include "disp_port_defines.svh"
module display_module_host_interface_tb;
	import disp_port_pkg::*;
	logic clk_sys_i, reset_i, req_valid_i, req_read_i, req_dc_i, chip_reset_i, out_ready_i, stall, sda;
	logic req_ready_o, rd_valid_o, out_valid_o, out_is_data_o, init_o;
	logic [1:0] mode_i;
	logic [7:0] req_data_i, read_data_i, rd_data_o, out_byte_o, noise;
	logic [1:0] modes[4] = '{2'h2, 2'h3, 2'h0, 2'h1};
	logic [8:0] exp_q[$]; // Words the device should hand out, in order
	int errors, total_checks;
	disp_port_if port_if();
	disp_host_end disp_host_end_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mode_i(mode_i),
		.req_valid_i(req_valid_i), .req_read_i(req_read_i), .req_dc_i(req_dc_i), .req_data_i(req_data_i),
		.chip_reset_i(chip_reset_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
		.rd_data_o(rd_data_o), .port(port_if.host));
	disp_dev_end disp_dev_end_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .read_data_i(read_data_i),
		.out_ready_i(out_ready_i), .out_valid_o(out_valid_o), .out_is_data_o(out_is_data_o),
		.out_byte_o(out_byte_o), .init_o(init_o), .port(port_if.dev));
	disp_port_assertions disp_port_assertions_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.bus_sel(port_if.bus_sel), .cs_n(port_if.cs_n), .rw_wr_n(port_if.rw_wr_n),
		.e_rd_n(port_if.e_rd_n), .d_dev_oe(port_if.d_dev_oe));
	////////////////////////////////////////////////////////////////////////
	// Released pins wander so a stale value never passes for data
	always @(posedge clk_sys_i) noise <= noise + 8'h35;
	// Two-wire data line is pulled up and low if any party pulls it
	assign sda = !((port_if.d_host_oe[1] && !port_if.d_host[1]) || (port_if.d_host_oe[2] && !port_if.d_host[2])
		|| (port_if.d_dev_oe[2] && !port_if.d_dev[2]));
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			port_if.d_in[i] = port_if.d_dev_oe[i] ? port_if.d_dev[i] : port_if.d_host_oe[i] ? port_if.d_host[i] : noise[i];
		if (port_if.bus_sel == `BUS_SEL_I2C)
		begin
			port_if.d_in[1] = sda;
			port_if.d_in[2] = sda;
		end
	end
	// Receiver stalls at random, or wholly while the buffer is being filled
	always @(posedge clk_sys_i) out_ready_i <= #1 !stall && (($urandom % 4) != 0);
	// Every accepted word and every read answer is compared at once
	always @(posedge clk_sys_i)
	begin
		if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
			chk_word({out_is_data_o, out_byte_o}, exp_q.size() ? exp_q.pop_front() : 9'h1FF);
		if (rd_valid_o === 1'b1)
			chk_word({1'b0, rd_data_o}, {1'b0, read_data_i});
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_flag(input logic got, input logic exp);
		chk_word({8'h00, got}, {8'h00, exp});
	endtask : chk_flag
	// One byte request; a stalled buffer keeps only two words
	task automatic send(input logic rd, input logic dc, input logic [7:0] dat);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		#1 req_valid_i = 1'b1;
		req_read_i = rd;
		req_dc_i = dc;
		req_data_i = dat;
		read_data_i = 8'($urandom);
		// Ready is looked at off the edge; the next edge then takes the request
		while (req_ready_o !== 1'b1 && n < 400)
		begin
			n++;
			@(posedge clk_sys_i);
			#1;
		end
		@(posedge clk_sys_i);
		chk_flag(n < 400, 1'b1);
		if (!rd && mode_i != `BUS_SEL_I2C && exp_q.size() < (stall ? 2 : 99))
			exp_q.push_back({dc, dat});
		#1 req_valid_i = 1'b0;
	endtask : send
	// Waits for the host to go idle and, unless stalled, the queue to empty
	task automatic drain();
		int n;
		n = 0;
		@(posedge clk_sys_i);
		#1;
		while ((req_ready_o !== 1'b1 || (!stall && exp_q.size() != 0)) && n < 500)
		begin
			n++;
			@(posedge clk_sys_i);
			#1;
		end
		chk_flag(n < 500, 1'b1);
	endtask : drain
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Watchdog sized well beyond the longest serial traffic
	initial
	begin
		#800000;
		errors++;
		end_sim();
	end
	initial
	begin
		{reset_i, stall, noise, errors, total_checks} = {1'b1, 1'b0, 8'h00, 32'd0, 32'd0};
		{mode_i, req_valid_i, req_read_i, req_dc_i, req_data_i, read_data_i} = {`BUS_SEL_8080, 19'h00000};
		{chip_reset_i, out_ready_i} = 2'b00;
		void'($urandom(17));
		repeat (12) @(posedge clk_sys_i);
		#1 reset_i = 1'b0;
		// Controller reset pin held low then released
		#1 chip_reset_i = 1'b1;
		repeat (5) @(posedge clk_sys_i);
		#1 chk_flag(init_o, 1'b1);
		chip_reset_i = 1'b0;
		repeat (5) @(posedge clk_sys_i);
		#1 chk_flag(init_o, 1'b0);
		$display("Test reset done");
		// Every strap code with both edge bytes and random traffic
		foreach (modes[k])
		begin
			mode_i = modes[k];
			send(1'b0, 1'b0, 8'h00);
			send(1'b0, 1'b1, 8'hFF);
			repeat (20) send(mode_i[1] & 1'($urandom), 1'($urandom), 8'($urandom));
			drain();
			$display("Test mode %0d done", mode_i);
		end
		// Receiver stalled: third word is dropped, two are held
		mode_i = `BUS_SEL_8080;
		stall = 1'b1;
		repeat (3) send(1'b0, 1'b1, 8'($urandom));
		drain();
		chk_flag(out_valid_o, 1'b1);
		stall = 1'b0;
		drain();
		$display("Test stall done");
		end_sim();
	end
endmodule : display_module_host_interface_tb
`default_nettype wire
